// >>> common/wdr_defines.vh
// Register offsets, field positions, codes and reset values of the watchdog register block
`ifndef WDR_DEFINES_VH
`define WDR_DEFINES_VH

// ----------------------------------------------------------------
// Register byte addresses (word aligned)
// ----------------------------------------------------------------
`define WDR_ADDR_CTL 4'h0
`define WDR_ADDR_UPPER 4'h4
`define WDR_ADDR_HIGH 4'h8
`define WDR_ADDR_LOW 4'hc
`define WDR_ADDR_CMD 4'h0
`define WDR_AW 4

// ----------------------------------------------------------------
// Unlock codes
// ----------------------------------------------------------------
`define WDR_CODE_FIRST 8'h55
`define WDR_CODE_SECOND 8'haa

// ----------------------------------------------------------------
// Control/status fields
// ----------------------------------------------------------------
`define WDR_BIT_POWER 7
`define WDR_BIT_STOP 6
`define WDR_BIT_WDOG 5
`define WDR_BIT_EXT 4
`define WDR_BIT_SM 0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define WDR_RELOAD_RESET 24'h000400
`define WDR_CTL_RESET 8'h80

// ----------------------------------------------------------------
// Reset cause codes
// ----------------------------------------------------------------
`define WDR_CAUSE_NONE 3'h0
`define WDR_CAUSE_POR 3'h1
`define WDR_CAUSE_PIN 3'h2
`define WDR_CAUSE_WDOG 3'h3
`define WDR_CAUSE_DBG 3'h4
`define WDR_CAUSE_SMR_GPIO 3'h5
`define WDR_CAUSE_SMR_WDOG 3'h6

`endif

// >>> hdl/wdr_regs.v
// Watchdog reload unlock, reload transfer and reset-cause status register block
// How it works
// - Code writes leave status bits unchanged.
// - Stray write relocks state machine.
// - Reload copied on enable and refresh.
// - Status register read-only, reports reset causes.
// - Read clears upper four bits afterwards.
// - Cause codes map to defined flags.
//
// Chosen here: register access over Wishbone and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "wdr_defines.vh"

module wdr_regs
(
	// Clock and reset
	input wire SYS_CLK,
	input wire RST_B,
	// Wishbone slave
	input wire WB_CYC_I,
	input wire WB_STB_I,
	input wire WB_WE_I,
	input wire [`WDR_AW-1:0] WB_ADR_I,
	input wire [3:0] WB_SEL_I,
	input wire [31:0] WB_DAT_I,
	output reg [31:0] WB_DAT_O,
	output wire WB_ACK_O,
	// Register writes elsewhere in the register file
	input wire OTHER_WR,
	// Watchdog control
	input wire WDOG_ENABLE,
	input wire REFRESH_EXEC,
	// Reset cause reporting
	input wire CAUSE_VALID,
	input wire [2:0] CAUSE_CODE,
	input wire STOP_MODE_IN,
	// Counter load
	output reg LOAD_STROBE,
	output reg [23:0] LOAD_VALUE,
	output wire [5:0] LOCK_STATE
);

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	reg ack_q;
	wire req = WB_CYC_I & WB_STB_I & ~ack_q;
	wire wr = req & WB_WE_I & WB_SEL_I[0];
	wire rd = req & ~WB_WE_I;
	wire hit_ctl = (WB_ADR_I == `WDR_ADDR_CTL);
	wire hit_upper = (WB_ADR_I == `WDR_ADDR_UPPER);
	wire hit_high = (WB_ADR_I == `WDR_ADDR_HIGH);
	wire hit_low = (WB_ADR_I == `WDR_ADDR_LOW);
	wire [7:0] wdat = WB_DAT_I[7:0];

	assign WB_ACK_O = ack_q;

	always @(posedge SYS_CLK or negedge RST_B)
	begin
		if (!RST_B)
			ack_q <= 1'b0;
		else
			ack_q <= req;
	end

	// ----------------------------------------------------------------
	// Unlock sequencer
	// ----------------------------------------------------------------
	wire allow_upper;
	wire allow_high;
	wire allow_low;
	// Every register write elsewhere, and every local write with byte lane 0 enabled, advances or resets the lock, except a repeated first code in ST_CODE1
	wire wr_any = wr | OTHER_WR;

	wdr_unlock_fsm u_fsm
	(
		.clk(SYS_CLK),
		.rst_b(RST_B),
		.wr_ctl(wr & hit_ctl & ~OTHER_WR),
		.wr_data(wdat),
		.wr_upper(wr & hit_upper & ~OTHER_WR),
		.wr_high(wr & hit_high & ~OTHER_WR),
		.wr_low(wr & hit_low & ~OTHER_WR),
		.wr_any(wr_any),
		.allow_upper(allow_upper),
		.allow_high(allow_high),
		.allow_low(allow_low),
		.state(LOCK_STATE)
	);

	// ----------------------------------------------------------------
	// Reload byte registers
	// ----------------------------------------------------------------
	localparam [23:0] reload_rst = `WDR_RELOAD_RESET;
	reg [7:0] reload_upper_byte_q;
	reg [7:0] reload_high_byte_q;
	reg [7:0] reload_low_byte_q;

	always @(posedge SYS_CLK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			reload_upper_byte_q <= reload_rst[23:16];
			reload_high_byte_q <= reload_rst[15:8];
			reload_low_byte_q <= reload_rst[7:0];
		end
		else
		begin
			// Writes land only in the granted order
			if (allow_upper && !OTHER_WR)
				reload_upper_byte_q <= wdat;
			if (allow_high && !OTHER_WR)
				reload_high_byte_q <= wdat;
			if (allow_low && !OTHER_WR)
				reload_low_byte_q <= wdat;
		end
	end

	// ----------------------------------------------------------------
	// Counter load on each enable rising edge and on refresh
	// ----------------------------------------------------------------
	reg enable_q;

	always @(posedge SYS_CLK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			enable_q <= 1'b0;
			LOAD_STROBE <= 1'b0;
			LOAD_VALUE <= 24'h000000;
		end
		else
		begin
			enable_q <= WDOG_ENABLE;
			LOAD_STROBE <= (WDOG_ENABLE & ~enable_q) | REFRESH_EXEC;
			if ((WDOG_ENABLE & ~enable_q) | REFRESH_EXEC)
				LOAD_VALUE <= {reload_upper_byte_q, reload_high_byte_q,
					reload_low_byte_q};
		end
	end

	// ----------------------------------------------------------------
	// Control/status register
	// ----------------------------------------------------------------
	localparam [7:0] ctl_rst = `WDR_CTL_RESET;
	reg [3:0] flags_q;
	reg [3:0] flags_d;
	reg sm_q;
	reg [3:0] cause_flags;
	wire rd_ctl = rd & hit_ctl;

	// Cause decode: power, stop, watchdog, external
	always @*
	begin
		case (CAUSE_CODE)
			`WDR_CAUSE_POR: cause_flags = 4'h8;
			`WDR_CAUSE_DBG: cause_flags = 4'h8;
			`WDR_CAUSE_PIN: cause_flags = 4'h1;
			`WDR_CAUSE_WDOG: cause_flags = 4'h2;
			`WDR_CAUSE_SMR_GPIO: cause_flags = 4'h4;
			`WDR_CAUSE_SMR_WDOG: cause_flags = 4'h6;
			default: cause_flags = 4'h0;
		endcase
	end

	always @*
	begin
		flags_d = flags_q;
		// Read clears first, a new cause in the same cycle wins
		if (rd_ctl)
			flags_d = 4'h0;
		if (CAUSE_VALID && cause_flags != 4'h0)
			flags_d = cause_flags;
	end

	always @(posedge SYS_CLK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			flags_q <= ctl_rst[7:4];
			sm_q <= 1'b0;
		end
		else
		begin
			// Writes, including the codes, never touch these bits
			flags_q <= flags_d;
			sm_q <= STOP_MODE_IN;
		end
	end

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------
	always @(posedge SYS_CLK or negedge RST_B)
	begin
		if (!RST_B)
			WB_DAT_O <= 32'h00000000;
		else if (rd)
		begin
			WB_DAT_O <= 32'h00000000;
			if (hit_ctl)
				WB_DAT_O[7:0] <= {flags_q, 3'h0, sm_q};
			else if (hit_upper)
				WB_DAT_O[7:0] <= reload_upper_byte_q;
			else if (hit_high)
				WB_DAT_O[7:0] <= reload_high_byte_q;
			else if (hit_low)
				WB_DAT_O[7:0] <= reload_low_byte_q;
		end
	end

endmodule // wdr_regs

`default_nettype wire

// >>> hdl/wdr_unlock_fsm.v
// Ordered unlock sequencer guarding the reload byte registers
`timescale 1ns/1ns
`default_nettype none
`include "wdr_defines.vh"

module wdr_unlock_fsm
(
	// Clock and reset
	input wire clk,
	input wire rst_b,
	// Register write events
	input wire wr_ctl,
	input wire [7:0] wr_data,
	input wire wr_upper,
	input wire wr_high,
	input wire wr_low,
	input wire wr_any,
	// Grants
	output wire allow_upper,
	output wire allow_high,
	output wire allow_low,
	output wire [5:0] state
);

	// ----------------------------------------------------------------
	// States
	// ----------------------------------------------------------------
	localparam [5:0] ST_LOCKED = 6'h01;
	localparam [5:0] ST_CODE1 = 6'h02;
	localparam [5:0] ST_CODE2 = 6'h04;
	localparam [5:0] ST_UPPER = 6'h08;
	localparam [5:0] ST_HIGH = 6'h10;
	localparam [5:0] ST_SPARE = 6'h20;

	reg [5:0] state_q;
	reg [5:0] state_d;

	assign allow_upper = (state_q == ST_CODE2) & wr_upper;
	assign allow_high = (state_q == ST_UPPER) & wr_high;
	assign allow_low = (state_q == ST_HIGH) & wr_low;
	assign state = state_q;

	always @*
	begin
		state_d = state_q;
		if (wr_any)
		begin
			// Any write that is not the expected next step relocks, except a repeated first code in ST_CODE1
			state_d = ST_LOCKED;
			case (state_q)
				ST_LOCKED:
				begin
					if (wr_ctl && wr_data == `WDR_CODE_FIRST)
						state_d = ST_CODE1;
				end
				ST_CODE1:
				begin
					if (wr_ctl && wr_data == `WDR_CODE_SECOND)
						state_d = ST_CODE2;
					else if (wr_ctl && wr_data == `WDR_CODE_FIRST)
						state_d = ST_CODE1;
				end
				ST_CODE2:
				begin
					if (wr_upper)
						state_d = ST_UPPER;
				end
				ST_UPPER:
				begin
					if (wr_high)
						state_d = ST_HIGH;
				end
				ST_HIGH:
				begin
					// Low byte ends the sequence and relocks
					state_d = ST_LOCKED;
				end
				default:
				begin
					state_d = ST_LOCKED;
				end
			endcase
		end
	end

	always @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			state_q <= ST_LOCKED;
		else
			state_q <= state_d;
	end

endmodule // wdr_unlock_fsm

`default_nettype wire

// >>> verif/wdr_regs_properties.sv
// Concurrent checks on the watchdog register block ports
`timescale 1ns/1ns
`default_nettype none
`include "wdr_defines.vh"
module wdr_regs_properties
(
	// Clock and inputs
	input wire logic SYS_CLK,
	input wire logic RST_B,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [`WDR_AW-1:0] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [31:0] WB_DAT_I,
	input wire logic OTHER_WR,
	input wire logic WDOG_ENABLE,
	input wire logic REFRESH_EXEC,
	// Outputs
	input wire logic WB_ACK_O,
	input wire logic LOAD_STROBE,
	input wire logic [5:0] LOCK_STATE
);
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!RST_B);
	wire logic wr;
	wire logic s;
	assign wr = WB_CYC_I && WB_STB_I && WB_WE_I && WB_SEL_I[0] && !WB_ACK_O && !OTHER_WR;
	assign s = wr && WB_ADR_I == `WDR_ADDR_CTL;
	// ----
	// Lock sequence and load
	// ----
	a_first_code: assert property (s && WB_DAT_I[7:0] == `WDR_CODE_FIRST
		&& LOCK_STATE == 6'h01 |=> LOCK_STATE == 6'h02) else $error("first code");
	a_second_code: assert property (s && WB_DAT_I[7:0] == `WDR_CODE_SECOND
		&& LOCK_STATE == 6'h02 |=> LOCK_STATE == 6'h04) else $error("second code");
	a_upper_step: assert property (wr && WB_ADR_I == `WDR_ADDR_UPPER
		&& LOCK_STATE == 6'h04 |=> LOCK_STATE == 6'h08) else $error("upper step");
	a_high_step: assert property (wr && WB_ADR_I == `WDR_ADDR_HIGH
		&& LOCK_STATE == 6'h08 |=> LOCK_STATE == 6'h10) else $error("high step");
	a_low_relocks: assert property (wr && WB_ADR_I == `WDR_ADDR_LOW
		&& LOCK_STATE == 6'h10 |=> LOCK_STATE == 6'h01) else $error("low relock");
	a_skip_relocks: assert property (wr && WB_ADR_I == `WDR_ADDR_LOW
		&& LOCK_STATE == 6'h04 |=> LOCK_STATE == 6'h01) else $error("skip relock");
	a_stray_relocks: assert property (OTHER_WR |=> LOCK_STATE == 6'h01)
		else $error("stray relock");
	a_refresh_loads: assert property (REFRESH_EXEC |=> LOAD_STROBE)
		else $error("refresh load");
	a_enable_loads: assert property ($rose(WDOG_ENABLE) |=> LOAD_STROBE)
		else $error("enable load");
	a_no_stray_load: assert property (!REFRESH_EXEC && !$rose(WDOG_ENABLE) |=>
		!LOAD_STROBE) else $error("stray load");
endmodule // wdr_regs_properties
bind wdr_regs wdr_regs_properties u_wdr_regs_properties (.*);
`default_nettype wire

// >>> verif/wdr_regs_tb.sv
// Self-checking bench for the watchdog register block
`timescale 1ns/1ns
`default_nettype none
`include "wdr_defines.vh"
module wdr_regs_tb;
	logic clk = 0, rst_b = 0, cyc = 0, we = 0, oth = 0, en = 0, rfs = 0, cv = 0, sm = 1;
	logic [3:0] adr = 4'h0;
	logic [7:0] dat = 8'h00;
	logic [2:0] cc = 3'h0;
	logic [31:0] q;
	logic [3:0] fl [7] = '{4'h0, 4'h8, 4'h1, 4'h2, 4'h8, 4'h4, 4'h6};
	wire logic [31:0] dat_o;
	wire logic ack, ld;
	wire logic [23:0] lv;
	int num_errors = 0, cmp_count = 0, tick = 0;
	always #10 clk = ~clk;
	wdr_regs u_wdr_regs (.SYS_CLK(clk), .RST_B(rst_b), .WB_CYC_I(cyc), .WB_STB_I(cyc),
		.WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I({24'h0, dat}),
		.WB_DAT_O(dat_o), .WB_ACK_O(ack), .OTHER_WR(oth), .WDOG_ENABLE(en),
		.REFRESH_EXEC(rfs), .CAUSE_VALID(cv), .CAUSE_CODE(cc), .STOP_MODE_IN(sm),
		.LOAD_STROBE(ld), .LOAD_VALUE(lv), .LOCK_STATE());
	// ----
	// Tasks
	// ----
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e)
		begin
			num_errors++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask
	task bus(input logic [3:0] a, input logic w, input logic [7:0] d);
		@(posedge clk);
		cyc <= 1;
		we <= w;
		adr <= a;
		dat <= d;
		@(posedge clk);
		while (ack !== 1'b1)
			@(posedge clk);
		q = dat_o;
		cyc <= 0;
	endtask
	task rd(input logic [3:0] a, input logic [31:0] e);
		bus(a, 0, 8'h00);
		chk("read", e, q);
	endtask
	task load(input logic r, input logic [23:0] e);
		@(posedge clk);
		if (r)
			rfs <= 1;
		else
			en <= 1;
		@(posedge clk);
		rfs <= 0;
		@(posedge clk);
		chk("load", {8'h1, e}, {7'h0, ld, lv});
	endtask
	task seq(input logic [23:0] v, input logic [1:0] k);
		bus(`WDR_ADDR_CTL, 1, `WDR_CODE_FIRST);
		bus(`WDR_ADDR_CTL, 1, `WDR_CODE_SECOND);
		if (k == 2'h1)
		begin
			oth <= 1;
			@(posedge clk);
			oth <= 0;
		end
		if (k == 2'h2)
			bus(`WDR_ADDR_LOW, 1, 8'h99);
		bus(`WDR_ADDR_UPPER, 1, v[23:16]);
		bus(`WDR_ADDR_HIGH, 1, v[15:8]);
		bus(`WDR_ADDR_LOW, 1, v[7:0]);
	endtask
	task results;
		$display("errors %0d compares %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	always @(posedge clk)
	begin
		tick <= tick + 1;
		if (tick == 3000)
		begin
			num_errors++;
			results;
		end
	end
	// ----
	// Main sequence
	// ----
	initial
	begin
		repeat (4) @(posedge clk);
		rst_b <= 1;
		rd(`WDR_ADDR_CTL, {24'h0, `WDR_CTL_RESET | 8'h01});
		rd(`WDR_ADDR_CTL, 32'h1);
		load(1, `WDR_RELOAD_RESET);
		bus(`WDR_ADDR_UPPER, 1, 8'h77);
		load(1, `WDR_RELOAD_RESET);
		bus(`WDR_ADDR_CTL, 1, 8'h00);
		seq(24'h123456, 2'h0);
		rd(`WDR_ADDR_CTL, 32'h1);
		load(1, 24'h123456);
		bus(`WDR_ADDR_UPPER, 1, 8'h77);
		load(1, 24'h123456);
		seq(24'h778899, 2'h1);
		load(1, 24'h123456);
		seq(24'h778899, 2'h2);
		load(1, 24'h123456);
		seq(24'habcdef, 2'h0);
		load(0, 24'habcdef);
		rd(`WDR_ADDR_UPPER, 32'hab);
		rd(`WDR_ADDR_HIGH, 32'hcd);
		rd(`WDR_ADDR_LOW, 32'hef);
		for (int i = 1; i < 7; i++)
		begin
			cv <= 1;
			cc <= i[2:0];
			@(posedge clk);
			cv <= 0;
			bus(`WDR_ADDR_CTL, 1, 8'hff);
			rd(`WDR_ADDR_CTL, {24'h0, fl[i], 4'h1});
			rd(`WDR_ADDR_CTL, 32'h1);
		end
		sm <= 0;
		rd(`WDR_ADDR_CTL, 32'h0);
		rd(4'h2, 32'h0);
		results;
	end
endmodule // wdr_regs_tb
`default_nettype wire
